// *** psri_pkg.sv ***
package psri_pkg;

  // ----------------------------------------------------------------
  // Widths and clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int IN_WIDTH      = 12;
  localparam int REG_WIDTH     = 10;
  localparam int CNT_WIDTH     = 8;

  // Speed grade used for the grade-dependent figures: 1 fast, 0 slow
  localparam bit FAST_GRADE = 1'b1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_WIDTH-1:0] REG_RESET      = 10'h000;
  localparam logic [IN_WIDTH-1:0]  IN_RESET       = 12'h000;
  localparam logic [CNT_WIDTH-1:0] CNT_RESET      = 8'h00;
  localparam logic [REG_WIDTH-1:0] POLARITY_RESET = 10'h000;

  // ----------------------------------------------------------------
  // Cycle rounding: least times round up, longest round down; neither goes below one cycle
  // ----------------------------------------------------------------
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  function automatic int floor_cyc(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : floor_cyc

  // ----------------------------------------------------------------
  // Times in their own units
  // ----------------------------------------------------------------
  localparam int SENSE_VALID_PULSE_NS  = 5;
  localparam int SENSE_IGNORE_PULSE_NS = 1;
  localparam int IDLE_MIN_NS           = 100;
  localparam int IDLE_MAX_NS           = 250;
  localparam int WAKE_ADD_NS           = FAST_GRADE ? 15 : 20;
  localparam int SLEEP_PULSE_HIGH_MIN_NS = 40;
  localparam int SLEEP_PULSE_LOW_MIN_NS  = FAST_GRADE ? 30 : 40;
  localparam int SLEEP_INPUT_HOLD_NS     = FAST_GRADE ? 15 : 25;
  localparam int WAKE_TO_INPUT_VALID_NS  = FAST_GRADE ? 20 : 25;
  localparam int WAKE_TO_CLOCK_VALID_NS  = FAST_GRADE ? 30 : 35;
  localparam int WAKE_TO_OUTPUT_VALID_NS = FAST_GRADE ? 35 : 45;
  localparam int POWER_UP_RESET_US       = 10;

  // ----------------------------------------------------------------
  // Timing counts in clock cycles
  // ----------------------------------------------------------------
  localparam int SENSE_VALID_PULSE_CYC  = ceil_cyc(SENSE_VALID_PULSE_NS);
  localparam int SENSE_IGNORE_PULSE_CYC = floor_cyc(SENSE_IGNORE_PULSE_NS);
  localparam int IDLE_ENTER_CYC         = ceil_cyc(IDLE_MIN_NS);
  localparam int IDLE_MAX_CYC           = floor_cyc(IDLE_MAX_NS);
  localparam int WAKE_ADD_CYC           = floor_cyc(WAKE_ADD_NS);
  localparam int SLEEP_HIGH_CYC  = ceil_cyc(SLEEP_PULSE_HIGH_MIN_NS);
  localparam int SLEEP_LOW_CYC   = ceil_cyc(SLEEP_PULSE_LOW_MIN_NS);
  localparam int SLEEP_HOLD_CYC  = ceil_cyc(SLEEP_INPUT_HOLD_NS);
  localparam int WAKE_INPUT_CYC  = ceil_cyc(WAKE_TO_INPUT_VALID_NS);
  localparam int WAKE_CLOCK_CYC  = ceil_cyc(WAKE_TO_CLOCK_VALID_NS);
  localparam int WAKE_OUTPUT_CYC = floor_cyc(WAKE_TO_OUTPUT_VALID_NS);
  localparam int POWER_UP_CYC    = floor_cyc(POWER_UP_RESET_US * 1000);

  // Host waits: longest of the figures that share one wait
  localparam int HOST_SLEEP_CYC =
    (SLEEP_HIGH_CYC > SLEEP_HOLD_CYC) ? SLEEP_HIGH_CYC : SLEEP_HOLD_CYC;
  localparam int HOST_WAKE_A =
    (SLEEP_LOW_CYC > WAKE_INPUT_CYC) ? SLEEP_LOW_CYC : WAKE_INPUT_CYC;
  localparam int HOST_WAKE_CYC =
    (HOST_WAKE_A > WAKE_CLOCK_CYC) ? HOST_WAKE_A : WAKE_CLOCK_CYC;

  // ----------------------------------------------------------------
  // State encodings (Gray along the usual path up to the wake state; the step back to active or run is not)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSRI_DEV_ACTIVE  = 2'h0,
    PSRI_DEV_STANDBY = 2'h1,
    PSRI_DEV_WAKING  = 2'h3
  } psri_dev_state_t;

  typedef enum logic [2:0] {
    PSRI_HOST_PWRUP = 3'h0,
    PSRI_HOST_RUN   = 3'h1,
    PSRI_HOST_HOLD  = 3'h3,
    PSRI_HOST_SLEEP = 3'h2,
    PSRI_HOST_WAKE  = 3'h6
  } psri_host_state_t;

endpackage : psri_pkg

// *** psri_if.sv ***
`timescale 1ns/1ps
interface psri_if;

  // Pins driven by the system logic
  logic                           autoSense;
  logic                           power_down_pin;
  logic [psri_pkg::IN_WIDTH-1:0]  dataIn;
  logic                           clockStrobe;
  logic                           preloadEn;
  logic [psri_pkg::REG_WIDTH-1:0] preloadData;

  // Pins driven by the device
  logic [psri_pkg::REG_WIDTH-1:0] regOut;
  logic                           standby;
  logic                           outValid;

  modport dev (
    input  autoSense,
    input  power_down_pin,
    input  dataIn,
    input  clockStrobe,
    input  preloadEn,
    input  preloadData,
    output regOut,
    output standby,
    output outValid
  );

  modport host (
    output autoSense,
    output power_down_pin,
    output dataIn,
    output clockStrobe,
    output preloadEn,
    output preloadData,
    input  regOut,
    input  standby,
    input  outValid
  );

endinterface : psri_if

// *** psri_device.sv ***
// Contract
// [R1] Auto variant sleeps after inputs stay idle
// [R2] Auto variant wakes on any input change
// [R3] Changes lasting one cycle wake device
// [R4] Sub-cycle glitches never count as changes
// [R5] Pin high sleeps, pin low wakes
// [R6] Power-down pin never feeds logic array
// [R7] Host holds pin high and low minimums
// [R8] Host keeps inputs valid after pin rises
// [R9] Host waits before inputs count after wake
// [R10] Host waits before clocking after wake
// [R11] Outputs valid soon after pin falls
// [R12] Power-up clears every register low
// [R13] Output pins apply polarity to registers
// [R14] Host keeps clock static during power-up
// [R15] Host clocks only after setup is met
// [R16] Each register can be preloaded synchronously
// [R17] Standby entered 100 to 250 ns idle
// [R18] Wake adds bounded delay to first outputs
// [R19] Registers keep contents through standby
`timescale 1ns/1ps
module psri_device #(
  parameter logic [psri_pkg::REG_WIDTH-1:0] OUT_POLARITY =
    psri_pkg::POLARITY_RESET
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Link to the system logic
  psri_if.dev       link
);

  // ----------------------------------------------------------------
  // Variant strap
  // ----------------------------------------------------------------
  logic autoVariant;
  logic strapTaken;
  logic next_autoVariant;
  logic next_strapTaken;

  // Strap caught on the first edge after reset release, not under it
  always_comb begin
    next_autoVariant = autoVariant;
    next_strapTaken  = 1'b1;
    if (!strapTaken) begin
      next_autoVariant = link.autoSense;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      autoVariant <= 1'b0;
      strapTaken  <= 1'b0;
    end else begin
      autoVariant <= next_autoVariant;
      strapTaken  <= next_strapTaken;
    end
  end

  // ----------------------------------------------------------------
  // Input activity sensor
  // ----------------------------------------------------------------
  logic [psri_pkg::IN_WIDTH-1:0]  prevIn;
  logic [psri_pkg::IN_WIDTH-1:0]  next_prevIn;
  logic [psri_pkg::CNT_WIDTH-1:0] idleCnt;
  logic [psri_pkg::CNT_WIDTH-1:0] next_idleCnt;
  logic                           inputChange;
  logic                           idleReached;

  // Compare against the last sampled level: a level that lasts one
  // clock is seen, anything shorter than a clock cannot be sampled
  always_comb begin
    next_prevIn = link.dataIn;
    inputChange = (link.dataIn != prevIn)   // [R3] [R4]
                  || link.clockStrobe
                  || link.preloadEn;
    next_idleCnt = idleCnt;
    if (inputChange) begin
      next_idleCnt = psri_pkg::CNT_RESET;
    end else if (!idleReached) begin
      next_idleCnt = idleCnt + 8'h01;
    end
  end

  // Saturates once idle long enough; standby decision reads it
  assign idleReached =
    (idleCnt >= psri_pkg::CNT_WIDTH'(psri_pkg::IDLE_ENTER_CYC)); // [R17]

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prevIn  <= psri_pkg::IN_RESET;
      idleCnt <= psri_pkg::CNT_RESET;
    end else begin
      prevIn  <= next_prevIn;
      idleCnt <= next_idleCnt;
    end
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  psri_pkg::psri_dev_state_t      state;
  psri_pkg::psri_dev_state_t      next_state;
  logic [psri_pkg::CNT_WIDTH-1:0] wakeCnt;
  logic [psri_pkg::CNT_WIDTH-1:0] next_wakeCnt;
  logic [psri_pkg::CNT_WIDTH-1:0] wakeLen;

  // Pin variant waits out the output-valid figure, auto the wake add
  assign wakeLen = autoVariant
    ? psri_pkg::CNT_WIDTH'(psri_pkg::WAKE_ADD_CYC)     // [R18]
    : psri_pkg::CNT_WIDTH'(psri_pkg::WAKE_OUTPUT_CYC); // [R11]

  always_comb begin
    next_state   = state;
    next_wakeCnt = wakeCnt;
    case (state)
      psri_pkg::PSRI_DEV_ACTIVE: begin
        next_wakeCnt = psri_pkg::CNT_RESET;
        if (!autoVariant && link.power_down_pin) begin
          next_state = psri_pkg::PSRI_DEV_STANDBY;             // [R5]
        end else if (autoVariant && idleReached && !inputChange) begin
          next_state = psri_pkg::PSRI_DEV_STANDBY;             // [R1]
        end
      end
      psri_pkg::PSRI_DEV_STANDBY: begin
        next_wakeCnt = psri_pkg::CNT_RESET;
        if (!autoVariant && !link.power_down_pin) begin
          next_state = psri_pkg::PSRI_DEV_WAKING;              // [R5]
        end else if (autoVariant && inputChange) begin
          next_state = psri_pkg::PSRI_DEV_WAKING;              // [R2]
        end
      end
      psri_pkg::PSRI_DEV_WAKING: begin
        next_wakeCnt = wakeCnt + 8'h01;
        if (!autoVariant && link.power_down_pin) begin
          next_state = psri_pkg::PSRI_DEV_STANDBY;
        end else if (next_wakeCnt >= wakeLen) begin
          next_state = psri_pkg::PSRI_DEV_ACTIVE;              // [R11]
        end
      end
      default: begin
        next_state   = psri_pkg::PSRI_DEV_ACTIVE;
        next_wakeCnt = psri_pkg::CNT_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state   <= psri_pkg::PSRI_DEV_ACTIVE;
      wakeCnt <= psri_pkg::CNT_RESET;
    end else begin
      state   <= next_state;
      wakeCnt <= next_wakeCnt;
    end
  end

  // ----------------------------------------------------------------
  // Output registers, preload and polarity
  // ----------------------------------------------------------------
  logic [psri_pkg::REG_WIDTH-1:0] qReg;
  logic [psri_pkg::REG_WIDTH-1:0] next_qReg;
  logic [psri_pkg::REG_WIDTH-1:0] outPin;
  logic [psri_pkg::REG_WIDTH-1:0] next_outPin;
  logic                           standbyOut;
  logic                           next_standbyOut;
  logic                           validOut;
  logic                           next_validOut;
  logic                           canClock;

  // Pin variant freezes the array while asleep; auto variant runs the
  // edge at once since the wake only stretches delays
  assign canClock = autoVariant || (state == psri_pkg::PSRI_DEV_ACTIVE);

  // The power-down pin never appears in the array function
  always_comb begin
    next_qReg = qReg;                                          // [R19]
    if (canClock && link.preloadEn) begin
      next_qReg = link.preloadData;                            // [R16]
    end else if (canClock && link.clockStrobe) begin
      next_qReg = link.dataIn[psri_pkg::REG_WIDTH-1:0];        // [R6]
    end
    next_outPin     = next_qReg ^ OUT_POLARITY;                // [R13]
    next_standbyOut = (next_state == psri_pkg::PSRI_DEV_STANDBY);
    next_validOut   = (next_state == psri_pkg::PSRI_DEV_ACTIVE);
  end

  // Reset clears the flops in one edge, far inside the power-up limit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      qReg       <= psri_pkg::REG_RESET;                       // [R12]
      outPin     <= psri_pkg::REG_RESET ^ OUT_POLARITY;        // [R13]
      standbyOut <= 1'b0;
      validOut   <= 1'b0;
    end else begin
      qReg       <= next_qReg;
      outPin     <= next_outPin;
      standbyOut <= next_standbyOut;
      validOut   <= next_validOut;
    end
  end

  // Pins
  assign link.regOut   = outPin;
  assign link.standby  = standbyOut;
  assign link.outValid = validOut;

endmodule : psri_device

// *** psri_host.sv ***
`timescale 1ns/1ps
module psri_host (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           resetn,
  // User side: configuration and inputs
  input  wire logic                           autoVariant,
  input  wire logic [psri_pkg::IN_WIDTH-1:0]  userIn,
  // User side: sleep request (level)
  input  wire logic                           sleepReq,
  // User side: clock and preload requests
  input  wire logic                           clockReq,
  input  wire logic                           preloadReq,
  input  wire logic [psri_pkg::REG_WIDTH-1:0] preloadValue,
  output logic                                hostReady,
  output logic                                asleep,
  // User side: device outputs
  output logic [psri_pkg::REG_WIDTH-1:0]      devOut,
  output logic                                devValid,
  // Link to the device
  psri_if.host                                link
);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  psri_pkg::psri_host_state_t     state;
  psri_pkg::psri_host_state_t     next_state;
  logic [psri_pkg::CNT_WIDTH-1:0] cnt;
  logic [psri_pkg::CNT_WIDTH-1:0] next_cnt;
  logic                           pdPin;
  logic                           next_pdPin;
  logic [psri_pkg::IN_WIDTH-1:0]  inPins;
  logic [psri_pkg::IN_WIDTH-1:0]  next_inPins;
  logic                           clkPin;
  logic                           next_clkPin;
  logic                           plEn;
  logic                           next_plEn;
  logic [psri_pkg::REG_WIDTH-1:0] plData;
  logic [psri_pkg::REG_WIDTH-1:0] next_plData;

  // Requests are taken only while running; a preload wins a clock
  assign hostReady = (state == psri_pkg::PSRI_HOST_RUN);
  assign asleep    = (state == psri_pkg::PSRI_HOST_SLEEP);

  always_comb begin
    next_state  = state;
    next_cnt    = cnt + 8'h01;
    next_pdPin  = pdPin;
    next_inPins = inPins;
    next_clkPin = 1'b0;
    next_plEn   = 1'b0;
    next_plData = plData;
    case (state)
      psri_pkg::PSRI_HOST_PWRUP: begin
        // Clock held static until the power-up reset has surely ended
        if (next_cnt >= psri_pkg::CNT_WIDTH'(psri_pkg::POWER_UP_CYC)) begin
          next_state = psri_pkg::PSRI_HOST_RUN;                // [R14]
          next_cnt   = psri_pkg::CNT_RESET;
        end
      end
      psri_pkg::PSRI_HOST_RUN: begin
        next_cnt    = psri_pkg::CNT_RESET;
        next_inPins = userIn;
        if (sleepReq && !autoVariant) begin
          next_state  = psri_pkg::PSRI_HOST_HOLD;
          next_pdPin  = 1'b1;
          next_inPins = inPins;                                // [R8]
        end else if (preloadReq) begin
          next_plEn   = 1'b1;
          next_plData = preloadValue;
        end else if (clockReq) begin
          next_clkPin = 1'b1;                                  // [R15]
        end
      end
      psri_pkg::PSRI_HOST_HOLD: begin
        // Pin high for its minimum, inputs frozen past the hold time
        if (next_cnt >= psri_pkg::CNT_WIDTH'(psri_pkg::HOST_SLEEP_CYC)) begin
          next_state = psri_pkg::PSRI_HOST_SLEEP;              // [R7] [R8]
          next_cnt   = psri_pkg::CNT_RESET;
        end
      end
      psri_pkg::PSRI_HOST_SLEEP: begin
        next_cnt = psri_pkg::CNT_RESET;
        if (!sleepReq) begin
          next_state = psri_pkg::PSRI_HOST_WAKE;
          next_pdPin = 1'b0;
        end
      end
      psri_pkg::PSRI_HOST_WAKE: begin
        next_inPins = userIn;
        // Low time, input and clock recovery all covered by one wait
        if (next_cnt >= psri_pkg::CNT_WIDTH'(psri_pkg::HOST_WAKE_CYC)) begin
          next_state = psri_pkg::PSRI_HOST_RUN;                // [R9] [R10]
          next_cnt   = psri_pkg::CNT_RESET;
        end
      end
      default: begin
        next_state = psri_pkg::PSRI_HOST_PWRUP;
        next_cnt   = psri_pkg::CNT_RESET;
        next_pdPin = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state  <= psri_pkg::PSRI_HOST_PWRUP;
      cnt    <= psri_pkg::CNT_RESET;
      pdPin  <= 1'b0;
      inPins <= psri_pkg::IN_RESET;
      clkPin <= 1'b0;
      plEn   <= 1'b0;
      plData <= psri_pkg::REG_RESET;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      pdPin  <= next_pdPin;
      inPins <= next_inPins;
      clkPin <= next_clkPin;
      plEn   <= next_plEn;
      plData <= next_plData;
    end
  end

  // Pins and user view
  assign link.autoSense      = autoVariant;
  assign link.power_down_pin = pdPin;
  assign link.dataIn         = inPins;
  assign link.clockStrobe    = clkPin;
  assign link.preloadEn      = plEn;
  assign link.preloadData    = plData;
  assign devOut              = link.regOut;
  assign devValid            = link.outValid;

endmodule : psri_host

// *** psri_properties.sv ***
`timescale 1ns/1ps
module psri_properties #(
  parameter logic [psri_pkg::REG_WIDTH-1:0] OUT_POLARITY = 10'h000
) (
  // Clock and reset
  input wire logic                           clk,
  input wire logic                           resetn,
  // Link signals
  input wire logic                           autoSense,
  input wire logic                           power_down_pin,
  input wire logic [psri_pkg::IN_WIDTH-1:0]  dataIn,
  input wire logic                           clockStrobe,
  input wire logic                           preloadEn,
  input wire logic [psri_pkg::REG_WIDTH-1:0] preloadData,
  input wire logic [psri_pkg::REG_WIDTH-1:0] regOut,
  input wire logic                           standby,
  input wire logic                           outValid
);
  // ----
  // Activity tracking
  // ----
  logic [psri_pkg::IN_WIDTH-1:0] prevData, next_prevData;
  logic [3:0]                    idleCnt, next_idleCnt;
  logic                          act;

  // Saturating count of quiet edges since the last activity
  assign act = (dataIn != prevData) || clockStrobe || preloadEn;
  always_comb begin
    next_prevData = dataIn;
    next_idleCnt  = (idleCnt == 4'hF) ? idleCnt : idleCnt + 4'h1;
    if (act || !resetn) begin
      next_idleCnt = 4'h0;
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    prevData <= next_prevData;
    idleCnt  <= next_idleCnt;
  end

  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Reset must be seen even while it is active, so no disable here
  AST_RESET_CLEAR: assert property (
    disable iff (1'b0) !resetn |=>
    regOut == OUT_POLARITY && !standby && !outValid)
    else $error("outputs not cleared by reset");
  AST_PRELOAD: assert property (preloadEn && (autoSense || outValid)
    |=> regOut == ($past(preloadData) ^ OUT_POLARITY))
    else $error("preload value not loaded");
  AST_CLOCK_LOAD: assert property (clockStrobe && !preloadEn
    && (autoSense || outValid)
    |=> regOut == ($past(dataIn[psri_pkg::REG_WIDTH-1:0]) ^ OUT_POLARITY))
    else $error("clocked value wrong");
  AST_HOLD: assert property (!clockStrobe && !preloadEn
    |=> $stable(regOut))
    else $error("register changed without a strobe");
  AST_PIN_SLEEP: assert property (!autoSense && power_down_pin
    |=> standby && !outValid)
    else $error("pin high did not enter standby");
  AST_PIN_WAKE: assert property (
    !autoSense && standby && !power_down_pin
    |=> !standby ##1 (outValid || $past(power_down_pin)))
    else $error("pin low did not wake in time");
  AST_AUTO_IDLE: assert property (autoSense && $rose(standby)
    |-> idleCnt >= 4'h2 && idleCnt <= 4'h5)
    else $error("standby entered outside idle window");
  AST_AUTO_ENTER: assert property (autoSense && idleCnt == 4'h5
    |-> standby)
    else $error("no standby after long idle");
  AST_AUTO_WAKE: assert property (
    autoSense && standby && act |-> ##[1:2] outValid)
    else $error("activity did not wake device");
endmodule : psri_properties

// *** test_pld_standby_and_register_init.sv ***
`timescale 1ns/1ps
module test_pld_standby_and_register_init;
  // Nonzero polarity so a cleared register is told apart from zero
  localparam logic [psri_pkg::REG_WIDTH-1:0] POL = 10'h2A5;
  typedef struct {logic pre; logic [11:0] val; logic [9:0] exp;} psri_row_t;

  logic        clk, resetn, autoVariant, sleepReq, clockReq, preloadReq;
  logic        hostReady, asleep, devValid;
  logic [11:0] userIn;
  logic [9:0]  preloadValue, devOut;
  int          fail_count, n_tests;
  psri_row_t   rows [4];

  // ----
  // Design
  // ----
  psri_if link ();
  psri_device #(.OUT_POLARITY(POL)) u_psri_device (
    .clk(clk), .resetn(resetn), .link(link));
  psri_host u_psri_host (
    .clk(clk), .resetn(resetn), .autoVariant(autoVariant),
    .userIn(userIn), .sleepReq(sleepReq), .clockReq(clockReq),
    .preloadReq(preloadReq), .preloadValue(preloadValue),
    .hostReady(hostReady), .asleep(asleep), .devOut(devOut),
    .devValid(devValid), .link(link));
  psri_properties #(.OUT_POLARITY(POL)) u_psri_properties (
    .clk(clk), .resetn(resetn), .autoSense(link.autoSense),
    .power_down_pin(link.power_down_pin), .dataIn(link.dataIn),
    .clockStrobe(link.clockStrobe), .preloadEn(link.preloadEn),
    .preloadData(link.preloadData), .regOut(link.regOut),
    .standby(link.standby), .outValid(link.outValid));

  // ----
  // Tasks
  // ----
  always #25 clk = ~clk;

  task automatic check_vec(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_vec

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // Strap is only sampled right after reset, so set it here
  task automatic do_reset(input logic auto);
    @(posedge clk);
    autoVariant <= auto;
    resetn      <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check_vec(devOut, POL);
    check_bit(link.standby, 1'b0);
    @(posedge clk);
    resetn <= 1'b1;
  endtask : do_reset

  // Bounded wait; a stuck host shows as a mismatch
  task automatic wait_ready;
    for (int i = 0; i < 400 && hostReady !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check_bit(hostReady, 1'b1);
  endtask : wait_ready

  // Host answers one cycle after the taking edge
  task automatic do_op(input logic pre, input logic doClock,
                       input logic [11:0] v);
    @(posedge clk);
    userIn       <= v;
    preloadValue <= v[9:0];
    clockReq     <= doClock;
    preloadReq   <= pre;
    @(posedge clk);
    clockReq   <= 1'b0;
    preloadReq <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : do_op

  // ----
  // Main sequence
  // ----
  initial begin
    clk          = 1'b0;
    resetn       = 1'b0;
    autoVariant  = 1'b0;
    sleepReq     = 1'b0;
    clockReq     = 1'b0;
    preloadReq   = 1'b0;
    userIn       = 12'h000;
    preloadValue = 10'h000;
    rows = '{'{1'b0, 12'hC00, POL}, '{1'b1, 12'h3FF, 10'h3FF ^ POL},
             '{1'b0, 12'h155, 10'h155 ^ POL},
             '{1'b1, 12'h2AA, 10'h2AA ^ POL}};
    do_reset(1'b0);
    wait_ready();
    check_bit(devValid, 1'b1);
    foreach (rows[i]) begin
      do_op(rows[i].pre, !rows[i].pre, rows[i].val);
      check_vec(devOut, rows[i].exp);
    end
    do_op(1'b1, 1'b1, 12'h0C3);
    check_vec(devOut, 10'h0C3 ^ POL);
    $display("test pin_loads done");
    @(posedge clk);
    sleepReq <= 1'b1;
    for (int i = 0; i < 50 && asleep !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check_bit(asleep, 1'b1);
    check_bit(link.power_down_pin, 1'b1);
    check_bit(link.standby, 1'b1);
    check_bit(devValid, 1'b0);
    // A clock request while asleep is refused and must not load
    do_op(1'b0, 1'b1, 12'h0FF);
    check_vec(devOut, 10'h0C3 ^ POL);
    @(posedge clk);
    sleepReq <= 1'b0;
    wait_ready();
    // Host is ready one edge before the device turns valid again
    @(posedge clk);
    #1;
    check_bit(devValid, 1'b1);
    check_vec(devOut, 10'h0C3 ^ POL);
    $display("test pin_sleep done");
    do_reset(1'b1);
    wait_ready();
    repeat (8) @(posedge clk);
    #1;
    check_bit(link.standby, 1'b1);
    check_vec(devOut, POL);
    @(posedge clk);
    userIn   <= userIn ^ 12'h800;
    sleepReq <= 1'b1;
    // Host flop delays the new level one edge, waking takes two more
    repeat (3) @(posedge clk);
    #1;
    check_bit(devValid, 1'b1);
    check_vec(devOut, POL);
    check_bit(link.power_down_pin, 1'b0);
    repeat (8) @(posedge clk);
    do_op(1'b0, 1'b1, 12'h0F0);
    check_vec(devOut, 10'h0F0 ^ POL);
    $display("test auto_sense done");
    stop_test();
  end

  // Whole run is under 500 cycles; ten times that means a hang
  initial begin
    #(5000 * psri_pkg::CLK_PERIOD_NS);
    fail_count++;
    stop_test();
  end
endmodule : test_pld_standby_and_register_init
